// ### hdl/fcr_run_ctrl.sv
// Run control, parameter slots, reference, aux output, display and storage.
// ********************************************************************
// ********************************************************************
`timescale 1ns/100ps
`default_nettype none
`include "fcr_params.svh"
module fcr_run_ctrl #(
  parameter int SET_W = 32,
  parameter int DW = 48,
  parameter int REF_WIN_CYC = `FCR_REF_WIN_CYC,
  parameter int PULSE_CYC = `FCR_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Run control
  input wire logic hold_key,
  input wire logic restart_req,
  input wire logic param_change,
  input wire logic stat_en,
  input wire logic meas_done,
  input wire logic stat_done,
  output logic meas_enable,
  output logic meas_restart,
  output logic stat_clear,
  output logic hold_led,
  // Parameter slots
  input wire logic enter_key,
  input wire logic save_req,
  input wire logic recall_req,
  input wire logic [3:0] slot_idx,
  input wire logic [SET_W-1:0] settings_in,
  output logic [SET_W-1:0] recall_data,
  output logic recall_valid,
  output logic [`FCR_SLOTS-1:0] slot_used,
  // Remote address
  input wire logic addr_wr,
  input wire logic [4:0] addr_in,
  output logic [4:0] gpib_addr,
  output logic addr_rej,
  // Reference
  input wire logic ref_auto,
  input wire logic ext_ref_in,
  output logic ref_use_ext,
  output fcr_pkg::fcr_ref_t ref_code,
  // Aux output
  input wire fcr_pkg::fcr_aux_t aux_sel,
  input wire logic limit_en,
  input wire logic in_limits,
  input wire logic burst_mode,
  input wire logic level_det,
  input wire logic count_gate,
  input wire logic acq_busy,
  output logic aux_out,
  // Display
  input wire fcr_pkg::fcr_disp_t disp_sel,
  input wire logic setup_screen,
  output fcr_pkg::fcr_disp_t disp_level,
  // Data storage
  input wire logic store_start,
  input wire logic store_stop,
  input wire logic store_read,
  input wire logic [DW-1:0] meas_value,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_data,
  output logic rsp_err,
  output logic rsp_last
);
  localparam int RW = $clog2(REF_WIN_CYC + 1);
  localparam int int_single_max = 2;
  generate
    if (SET_W < 1 || DW < 1 || REF_WIN_CYC < 200)
    begin : g_bad
      $error("fcr_run_ctrl: unsupported parameter values");
    end
  endgenerate

  // ********************************************************************
  // Hold and restart sequencing
  // ********************************************************************
  fcr_pkg::fcr_run_t run_r, run_nxt;
  always_comb
  begin
    run_nxt = run_r;
    case (run_r)
      fcr_pkg::FCR_RUN:
        if (hold_key)
          run_nxt = fcr_pkg::FCR_HELD;
      fcr_pkg::FCR_HELD:
        if (hold_key)
          run_nxt = fcr_pkg::FCR_RUN;
        else if (restart_req || param_change)
          run_nxt = stat_en ? fcr_pkg::FCR_ARM : fcr_pkg::FCR_ONE;
      fcr_pkg::FCR_ONE:
        if (hold_key)
          run_nxt = fcr_pkg::FCR_RUN;
        else if (meas_done)
          run_nxt = fcr_pkg::FCR_HELD;
      fcr_pkg::FCR_ARM:
        if (hold_key)
          run_nxt = fcr_pkg::FCR_RUN;
        else if (stat_done)
          run_nxt = fcr_pkg::FCR_HELD;
      default:
        run_nxt = fcr_pkg::FCR_RUN;
    endcase
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      run_r <= fcr_pkg::FCR_RUN;
    else if (ce)
      run_r <= run_nxt;
  end
  // The LED stays lit through a single shot: the unit is still in hold mode
  assign hold_led = (run_r != fcr_pkg::FCR_RUN);
  assign meas_enable = (run_r != fcr_pkg::FCR_HELD);
  // A panel change while held restarts too, so the shot starts clean
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meas_restart <= 1'b0;
      stat_clear <= 1'b0;
    end
    else if (ce)
    begin
      meas_restart <= restart_req || (run_r == fcr_pkg::FCR_HELD && param_change);
      stat_clear <= restart_req && stat_en;
    end
  end

  // ********************************************************************
  // Parameter slots
  // ********************************************************************
  // Slot contents are non-volatile and reset leaves them alone; the flags clear only with enter held over reset
  logic [SET_W-1:0] slot_mem [`FCR_SLOTS];
  logic init_done_r;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      init_done_r <= 1'b0;
    else if (ce)
      init_done_r <= 1'b1;
  end
  always_ff @(posedge mclk)
  begin
    if (ce)
    begin
      if (!init_done_r && enter_key)
        slot_used <= '0;
      else if (save_req && slot_idx < 4'(`FCR_SLOTS))
        slot_used[slot_idx] <= 1'b1;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (ce && save_req && slot_idx < 4'(`FCR_SLOTS))
      slot_mem[slot_idx] <= settings_in;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      recall_data <= '0;
      recall_valid <= 1'b0;
    end
    else if (ce)
    begin
      recall_valid <= 1'b0;
      if (recall_req && slot_idx < 4'(`FCR_SLOTS) && slot_used[slot_idx])
      begin
        recall_data <= slot_mem[slot_idx];
        recall_valid <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // Remote address
  // ********************************************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      gpib_addr <= `FCR_GPIB_RST;
      addr_rej <= 1'b0;
    end
    else if (ce)
    begin
      addr_rej <= addr_wr && (addr_in > `FCR_GPIB_MAX);
      if (addr_wr && addr_in <= `FCR_GPIB_MAX)
        gpib_addr <= addr_in;
    end
  end

  // ********************************************************************
  // Reference detection and selection
  // ********************************************************************
  // Edges of the reference are counted over a fixed window; a count far
  // from every legal rate means no usable reference is present
  logic ext_ref_d_r;
  logic [RW-1:0] win_r;
  logic [7:0] edge_r;
  fcr_pkg::fcr_ref_t det_r;
  function automatic logic fcr_near(input logic [7:0] c, input int nom);
    fcr_near = (c >= 8'(nom - `FCR_REF_TOL)) && (c <= 8'(nom + `FCR_REF_TOL));
  endfunction
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ext_ref_d_r <= 1'b0;
      win_r <= '0;
      edge_r <= '0;
      det_r <= fcr_pkg::FCR_REF_INT;
    end
    else if (ce)
    begin
      ext_ref_d_r <= ext_ref_in;
      if (win_r == RW'(REF_WIN_CYC - 1))
      begin
        win_r <= '0;
        edge_r <= '0;
        if (fcr_near(edge_r, `FCR_REF_CNT_1M))
          det_r <= fcr_pkg::FCR_REF_1M;
        else if (fcr_near(edge_r, `FCR_REF_CNT_2M))
          det_r <= fcr_pkg::FCR_REF_2M;
        else if (fcr_near(edge_r, `FCR_REF_CNT_5M))
          det_r <= fcr_pkg::FCR_REF_5M;
        else if (fcr_near(edge_r, `FCR_REF_CNT_10M))
          det_r <= fcr_pkg::FCR_REF_10M;
        else
          det_r <= fcr_pkg::FCR_REF_INT;
      end
      else
      begin
        win_r <= win_r + RW'(1);
        if (ext_ref_in && !ext_ref_d_r && edge_r != 8'hff)
          edge_r <= edge_r + 8'h01;
      end
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ref_use_ext <= 1'b0;
      ref_code <= fcr_pkg::FCR_REF_INT;
    end
    else if (ce)
    begin
      ref_use_ext <= ref_auto && (det_r != fcr_pkg::FCR_REF_INT);
      ref_code <= ref_auto ? det_r : fcr_pkg::FCR_REF_INT;
    end
  end

  // ********************************************************************
  // Aux output
  // ********************************************************************
  logic end_pulse_n, rest_pulse_n;
  fcr_pulse #(.PULSE_CYC(PULSE_CYC)) u_end_pulse (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .trig(meas_done),
    .pulse_n(end_pulse_n)
  );
  fcr_pulse #(.PULSE_CYC(PULSE_CYC)) u_rest_pulse (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .trig(restart_req),
    .pulse_n(rest_pulse_n)
  );
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      aux_out <= 1'b1;
    else if (ce)
    begin
      case (aux_sel)
        fcr_pkg::FCR_AUX_OFF: aux_out <= 1'b1;
        fcr_pkg::FCR_AUX_GO: aux_out <= limit_en && in_limits;
        fcr_pkg::FCR_AUX_END: aux_out <= end_pulse_n;
        fcr_pkg::FCR_AUX_LVL: aux_out <= burst_mode ? level_det : 1'b1;
        fcr_pkg::FCR_AUX_GATE: aux_out <= count_gate;
        fcr_pkg::FCR_AUX_REST: aux_out <= rest_pulse_n;
        fcr_pkg::FCR_AUX_ACQ: aux_out <= !acq_busy;
        default: aux_out <= 1'b1;
      endcase
    end
  end

  // ********************************************************************
  // Display intensity
  // ********************************************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      disp_level <= fcr_pkg::FCR_DISP_100;
    else if (ce)
    begin
      if (disp_sel == fcr_pkg::FCR_DISP_OFF && setup_screen)
        disp_level <= fcr_pkg::FCR_DISP_25;
      else if (disp_sel > fcr_pkg::FCR_DISP_100)
        disp_level <= fcr_pkg::FCR_DISP_100;
      else
        disp_level <= disp_sel;
    end
  end

  // ********************************************************************
  // Data storage
  // ********************************************************************
  fcr_pkg::fcr_store_t st_r;
  logic st_full, st_rd_start, st_rd_valid, st_rd_last, err_nxt;
  logic [DW-1:0] st_rd_data;
  assign err_nxt = (store_read && st_r == fcr_pkg::FCR_ST_STORE)
                || ((store_stop || store_read) && !st_full);
  // The controller pulls results only from a stopped, full store
  assign st_rd_start = store_read && st_r == fcr_pkg::FCR_ST_STOPPED && st_full;
  fcr_store #(.DW(DW), .DEPTH(`FCR_STORE_DEPTH)) u_store (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .clr(store_start),
    .wr_en(meas_done && st_r == fcr_pkg::FCR_ST_STORE),
    .wr_data(meas_value),
    .rd_start(st_rd_start),
    .rd_valid(st_rd_valid),
    .rd_data(st_rd_data),
    .rd_last(st_rd_last),
    .full(st_full)
  );
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      st_r <= fcr_pkg::FCR_ST_IDLE;
    else if (ce)
    begin
      case (st_r)
        fcr_pkg::FCR_ST_IDLE:
          if (store_start)
            st_r <= fcr_pkg::FCR_ST_STORE;
        fcr_pkg::FCR_ST_STORE:
          if (store_stop)
            st_r <= st_full ? fcr_pkg::FCR_ST_STOPPED : fcr_pkg::FCR_ST_IDLE;
        fcr_pkg::FCR_ST_STOPPED:
          if (store_start)
            st_r <= fcr_pkg::FCR_ST_STORE;
        default:
          st_r <= fcr_pkg::FCR_ST_IDLE;
      endcase
    end
  end
  // Errors answer with zero data; a read-out stream never overlaps one
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_err <= 1'b0;
      rsp_last <= 1'b0;
    end
    else if (ce)
    begin
      rsp_valid <= st_rd_valid || err_nxt;
      rsp_err <= err_nxt && !st_rd_valid;
      rsp_data <= st_rd_valid ? st_rd_data : '0;
      rsp_last <= st_rd_last || (err_nxt && !st_rd_valid);
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  sequence s_held_trig;
    run_r == fcr_pkg::FCR_HELD && !hold_key && (restart_req || param_change) && !stat_en;
  endsequence
  sequence s_one_done;
    !hold_key && meas_done;
  endsequence
  a_hold_enter: assert property (@(posedge mclk) disable iff (rst || !ce)
    run_r == fcr_pkg::FCR_RUN && hold_key |=> hold_led && !meas_enable)
    else $error("hold not entered");
  a_hold_resume: assert property (@(posedge mclk) disable iff (rst || !ce)
    hold_led && hold_key |=> !hold_led && meas_enable)
    else $error("hold not released");
  a_single_shot: assert property (@(posedge mclk) disable iff (rst || !ce)
    s_held_trig ##1 s_one_done |=> run_r == fcr_pkg::FCR_HELD && hold_led)
    else $error("single shot not ended in hold");
  a_arm_stat: assert property (@(posedge mclk) disable iff (rst || !ce)
    run_r == fcr_pkg::FCR_ARM && !hold_key && !stat_done |=> run_r == fcr_pkg::FCR_ARM)
    else $error("re-arm left early");
  a_stat_clear: assert property (@(posedge mclk) disable iff (rst || !ce)
    restart_req && stat_en |=> stat_clear && meas_restart)
    else $error("sample count not cleared");
  a_addr_range: assert property (@(posedge mclk) disable iff (rst || !ce)
    addr_wr && addr_in > `FCR_GPIB_MAX |=> addr_rej && gpib_addr == $past(gpib_addr))
    else $error("out-of-range address taken");
  a_aux_off: assert property (@(posedge mclk) disable iff (rst || !ce)
    aux_sel == fcr_pkg::FCR_AUX_OFF |=> aux_out)
    else $error("aux not high when off");
  a_go_disabled: assert property (@(posedge mclk) disable iff (rst || !ce)
    aux_sel == fcr_pkg::FCR_AUX_GO && !limit_en |=> !aux_out)
    else $error("go output high while disabled");
  a_end_pulse: assert property (@(posedge mclk) disable iff (rst || !ce)
    meas_done && aux_sel == fcr_pkg::FCR_AUX_END ##1 aux_sel == fcr_pkg::FCR_AUX_END
    |=> ##[0:int_single_max] !aux_out)
    else $error("count end pulse missing");
  a_read_storing: assert property (@(posedge mclk) disable iff (rst || !ce)
    store_read && st_r == fcr_pkg::FCR_ST_STORE && !st_rd_valid
    |=> rsp_valid && rsp_err && rsp_data == '0)
    else $error("read while storing not refused");
  a_disp_setup: assert property (@(posedge mclk) disable iff (rst || !ce)
    disp_sel == fcr_pkg::FCR_DISP_OFF && setup_screen |=> disp_level == fcr_pkg::FCR_DISP_25)
    else $error("setup screen dark");
  a_rest_width: assert property (@(posedge mclk) disable iff (rst || !ce)
    $fell(rest_pulse_n) |-> !rest_pulse_n [*8])
    else $error("restart pulse too short");
endmodule // fcr_run_ctrl
`default_nettype wire

// ### shared/fcr_params.svh
// Constants of the counter run-control block: timing counts, limits, reset values.
`ifndef FCR_PARAMS_SVH
`define FCR_PARAMS_SVH
// ********************************************************************
// Clock and timing
// ********************************************************************
`define FCR_CLK_MHZ 200
`define FCR_PULSE_NS 1000
`define FCR_PULSE_CYC ((`FCR_PULSE_NS * `FCR_CLK_MHZ + 999) / 1000)
`define FCR_REF_WIN_NS 10000
`define FCR_REF_WIN_CYC ((`FCR_REF_WIN_NS * `FCR_CLK_MHZ + 999) / 1000)
// Reference edges expected per window, and the tolerance on each
`define FCR_REF_CNT_1M 10
`define FCR_REF_CNT_2M 20
`define FCR_REF_CNT_5M 50
`define FCR_REF_CNT_10M 100
`define FCR_REF_TOL 2
// ********************************************************************
// Limits and reset values
// ********************************************************************
`define FCR_SLOTS 10
`define FCR_GPIB_MAX 5'h1e
`define FCR_GPIB_RST 5'h08
`define FCR_STORE_DEPTH 100
`endif

// ### shared/fcr_pkg.sv
// Types of the counter run-control block.
package fcr_pkg;
  typedef enum logic [3:0] {
    FCR_RUN = 4'h1,
    FCR_HELD = 4'h2,
    FCR_ONE = 4'h4,
    FCR_ARM = 4'h8
  } fcr_run_t;
  typedef enum logic [2:0] {
    FCR_AUX_OFF = 3'h0,
    FCR_AUX_GO = 3'h1,
    FCR_AUX_END = 3'h2,
    FCR_AUX_LVL = 3'h3,
    FCR_AUX_GATE = 3'h4,
    FCR_AUX_REST = 3'h5,
    FCR_AUX_ACQ = 3'h6
  } fcr_aux_t;
  typedef enum logic [2:0] {
    FCR_DISP_OFF = 3'h0,
    FCR_DISP_25 = 3'h1,
    FCR_DISP_50 = 3'h2,
    FCR_DISP_75 = 3'h3,
    FCR_DISP_100 = 3'h4
  } fcr_disp_t;
  typedef enum logic [2:0] {
    FCR_REF_INT = 3'h0,
    FCR_REF_1M = 3'h1,
    FCR_REF_2M = 3'h2,
    FCR_REF_5M = 3'h3,
    FCR_REF_10M = 3'h4
  } fcr_ref_t;
  typedef enum logic [2:0] {
    FCR_ST_IDLE = 3'h1,
    FCR_ST_STORE = 3'h2,
    FCR_ST_STOPPED = 3'h4
  } fcr_store_t;
endpackage

// ### hdl/fcr_pulse.sv
// Retriggerable active-low pulse of fixed width.
`timescale 1ns/100ps
`default_nettype none
`include "fcr_params.svh"
module fcr_pulse #(
  parameter int PULSE_CYC = `FCR_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic trig,
  output logic pulse_n
);
  localparam int CW = $clog2(PULSE_CYC + 1);
  logic [CW-1:0] cnt_r;
  generate
    if (PULSE_CYC < 8)
    begin : g_bad
      $error("fcr_pulse: PULSE_CYC too small");
    end
  endgenerate
  // A new trigger reloads the count, so the width restarts
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      pulse_n <= 1'b1;
    end
    else if (ce)
    begin
      if (trig)
      begin
        cnt_r <= CW'(PULSE_CYC);
        pulse_n <= 1'b0;
      end
      else if (cnt_r > CW'(1))
        cnt_r <= cnt_r - CW'(1);
      else if (cnt_r == CW'(1))
      begin
        cnt_r <= '0;
        pulse_n <= 1'b1;
      end
    end
  end
  a_pulse_low: assert property (@(posedge mclk) disable iff (rst || !ce)
    trig |=> !pulse_n [*8]) else $error("pulse ended too early");
endmodule // fcr_pulse
`default_nettype wire

// ### hdl/fcr_store.sv
// Rolling result store, read out oldest to newest.
`timescale 1ns/100ps
`default_nettype none
`include "fcr_params.svh"
module fcr_store #(
  parameter int DW = 48,
  parameter int DEPTH = `FCR_STORE_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [DW-1:0] wr_data,
  input wire logic rd_start,
  output logic rd_valid,
  output logic [DW-1:0] rd_data,
  output logic rd_last,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r, rptr_r;
  logic [AW:0] cnt_r, rcnt_r;
  logic busy_r;
  assign full = (cnt_r == (AW+1)'(DEPTH));
  function automatic logic [AW-1:0] fcr_inc(input logic [AW-1:0] p);
    fcr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction
  // Writing past a full store overwrites the oldest entry
  always_ff @(posedge mclk)
  begin
    if (ce && wr_en)
      mem[wptr_r] <= wr_data;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wptr_r <= '0;
      cnt_r <= '0;
    end
    else if (ce)
    begin
      if (clr)
      begin
        wptr_r <= '0;
        cnt_r <= '0;
      end
      else if (wr_en)
      begin
        wptr_r <= fcr_inc(wptr_r);
        if (!full)
          cnt_r <= cnt_r + (AW+1)'(1);
      end
    end
  end
  // Once full, the write pointer also marks the oldest entry
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
      rptr_r <= '0;
      rcnt_r <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      rd_last <= 1'b0;
    end
    else if (ce)
    begin
      rd_valid <= busy_r;
      rd_last <= busy_r && (rcnt_r == (AW+1)'(DEPTH - 1));
      if (busy_r)
      begin
        rd_data <= mem[rptr_r];
        rptr_r <= fcr_inc(rptr_r);
        rcnt_r <= rcnt_r + (AW+1)'(1);
        if (rcnt_r == (AW+1)'(DEPTH - 1))
          busy_r <= 1'b0;
      end
      else if (rd_start)
      begin
        busy_r <= 1'b1;
        rptr_r <= wptr_r;
        rcnt_r <= '0;
      end
    end
  end
  a_store_sat: assert property (@(posedge mclk) disable iff (rst || !ce)
    full && wr_en && !clr |=> full) else $error("store lost fill");
endmodule // fcr_store
`default_nettype wire

// ### bench/fcr_core_model.sv
// Measurement core stand-in: one result every PER cycles while enabled.
`timescale 1ns/100ps
`default_nettype none
module fcr_core_model #(
  parameter int PER = 300
) (
  input wire logic mclk,
  input wire logic go,
  input wire logic meas_enable,
  output logic meas_done = 1'b0,
  output logic [47:0] meas_value = 48'h0
);
  int cnt = 0;
  // Values count up so that any reordering in the store shows
  always @(negedge mclk)
  begin
    meas_done <= 1'b0;
    if (go && meas_enable)
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    if (go && meas_enable && cnt == PER - 1)
    begin
      meas_done <= 1'b1;
      meas_value <= meas_value + 48'h1;
    end
  end
endmodule // fcr_core_model
`default_nettype wire

// ### bench/fcr_run_ctrl_test.sv
// Self-checking bench for the run-control and aux-output block.
`timescale 1ns/100ps
`default_nettype none
module fcr_run_ctrl_test;
  logic mclk, rst, hold_key, restart_req, param_change, meas_done, meas_enable, meas_restart;
  logic stat_clear, hold_led, enter_key, save_req, recall_req, recall_valid, addr_wr, addr_rej;
  logic ref_auto, ext_ref_in, ref_use_ext, limit_en, in_limits, burst_mode, level_det;
  logic count_gate, acq_busy, aux_out, setup_screen, store_start, store_stop, store_read;
  logic rsp_valid, rsp_err, rsp_last, go, ref_on, ce, stat_en, stat_done;
  logic [3:0] slot_idx;
  logic [31:0] settings_in, recall_data;
  logic [9:0] slot_used;
  logic [4:0] addr_in, gpib_addr;
  logic [47:0] meas_value, rsp_data, prev;
  fcr_pkg::fcr_ref_t ref_code;
  fcr_pkg::fcr_aux_t aux_sel;
  fcr_pkg::fcr_disp_t disp_sel, disp_level;
  int n_mismatch = 0, total_checks = 0, cycles = 0, n;
  fcr_run_ctrl fcr_run_ctrl_inst (.mclk, .rst, .ce, .hold_key, .restart_req, .param_change,
    .stat_en, .meas_done, .stat_done, .meas_enable, .meas_restart, .stat_clear,
    .hold_led, .enter_key, .save_req, .recall_req, .slot_idx, .settings_in, .recall_data,
    .recall_valid, .slot_used, .addr_wr, .addr_in, .gpib_addr, .addr_rej, .ref_auto, .ext_ref_in,
    .ref_use_ext, .ref_code, .aux_sel, .limit_en, .in_limits, .burst_mode, .level_det,
    .count_gate, .acq_busy, .aux_out, .disp_sel, .setup_screen, .disp_level, .store_start,
    .store_stop, .store_read, .meas_value, .rsp_valid, .rsp_data, .rsp_err, .rsp_last);
  fcr_core_model fcr_core_model_inst (.mclk, .go, .meas_enable, .meas_done, .meas_value);
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // 10 MHz reference, toggling on system clock falling edges
  always #50 if (ref_on) ext_ref_in = ~ext_ref_in;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_mismatch++;
      report_and_stop;
    end
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic pl(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask
  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Enter held over release clears the slot-used flags
  task automatic rs(input logic ek);
    enter_key = ek;
    rst = 1'b1;
    cyc(6);
    rst = 1'b0;
    cyc(1);
    enter_key = 1'b0;
  endtask
  task automatic wid(input int ex);
    int i;
    int w;
    i = 0;
    w = 0;
    while (aux_out !== 1'b0 && i < 400)
    begin
      @(negedge mclk);
      i++;
    end
    while (aux_out === 1'b0 && w < 400)
    begin
      @(negedge mclk);
      w++;
    end
    chk(48'(w), 48'(ex));
  endtask
  task automatic aux_pass(input logic [5:0] v, input logic [6:0] ex);
    {limit_en, in_limits, burst_mode, level_det, count_gate, acq_busy} = v;
    for (int s = 0; s < 7; s++)
    begin
      aux_sel = fcr_pkg::fcr_aux_t'(s);
      cyc(3);
      chk(aux_out, ex[s]);
    end
  endtask
  task automatic err_rsp;
    int i;
    i = 0;
    while (rsp_valid !== 1'b1 && i < 5)
    begin
      @(negedge mclk);
      i++;
    end
    chk({rsp_valid, rsp_err, rsp_data}, {2'h3, 48'h0});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    {hold_key, restart_req, param_change, save_req, recall_req, addr_wr, ref_auto} = '0;
    {ext_ref_in, setup_screen, store_start, store_stop, store_read, go, ref_on} = '0;
    {stat_en, stat_done} = '0;
    ce = 1'b1;
    {slot_idx, settings_in, addr_in} = '0;
    aux_sel = fcr_pkg::FCR_AUX_OFF;
    disp_sel = fcr_pkg::FCR_DISP_OFF;
    rs(1'b1);
    aux_pass(6'h3b, 7'h37);
    pl(hold_key);
    chk({hold_led, meas_enable}, 2'h2);
    go = 1'b1;
    pl(restart_req);
    chk({meas_restart, meas_enable}, 2'h3);
    cyc(310);
    chk({hold_led, meas_enable}, 2'h2);
    pl(param_change);
    chk(meas_restart, 1);
    cyc(310);
    pl(hold_key);
    chk({hold_led, meas_enable}, 2'h1);
    pl(hold_key);
    stat_en = 1'b1;
    pl(restart_req);
    chk({stat_clear, meas_restart, hold_led, meas_enable}, 4'hf);
    cyc(400);
    chk(meas_enable, 1);
    pl(stat_done);
    chk({hold_led, meas_enable}, 2'h2);
    stat_en = 1'b0;
    pl(hold_key);
    chk({hold_led, meas_enable}, 2'h1);
    go = 1'b0;
    $display("hold done");
    slot_idx = 4'h3;
    settings_in = 32'h5a5a_c3c3;
    pl(save_req);
    pl(recall_req);
    chk({recall_valid, recall_data}, {1'b1, 32'h5a5a_c3c3});
    slot_idx = 4'h9;
    pl(recall_req);
    chk(recall_valid, 0);
    rs(1'b0);
    chk(slot_used, 10'h008);
    rs(1'b1);
    chk(slot_used, 10'h000);
    addr_in = 5'h1e;
    pl(addr_wr);
    chk({addr_rej, gpib_addr}, 6'h1e);
    addr_in = 5'h1f;
    pl(addr_wr);
    chk({addr_rej, gpib_addr}, 6'h3e);
    addr_in = 5'h05;
    ce = 1'b0;
    pl(addr_wr);
    ce = 1'b1;
    chk(gpib_addr, 5'h1e);
    $display("slots done");
    aux_pass(6'h3b, 7'h37);
    aux_pass(6'h10, 7'h6d);
    aux_sel = fcr_pkg::FCR_AUX_END;
    go = 1'b1;
    wid(200);
    go = 1'b0;
    aux_sel = fcr_pkg::FCR_AUX_REST;
    fork
      pl(restart_req);
      wid(200);
    join
    fork
      begin
        pl(restart_req);
        cyc(50);
        pl(restart_req);
      end
      wid(251);
    join
    $display("aux done");
    setup_screen = 1'b1;
    cyc(2);
    chk(disp_level, fcr_pkg::FCR_DISP_25);
    setup_screen = 1'b0;
    cyc(2);
    chk(disp_level, fcr_pkg::FCR_DISP_OFF);
    disp_sel = fcr_pkg::FCR_DISP_75;
    cyc(2);
    chk(disp_level, fcr_pkg::FCR_DISP_75);
    ref_auto = 1'b1;
    ref_on = 1'b1;
    cyc(4500);
    chk({ref_use_ext, ref_code}, {1'b1, fcr_pkg::FCR_REF_10M});
    ref_auto = 1'b0;
    cyc(4500);
    chk({ref_use_ext, ref_code}, {1'b0, fcr_pkg::FCR_REF_INT});
    $display("config done");
    pl(store_start);
    pl(store_read);
    err_rsp;
    pl(store_start);
    pl(store_stop);
    err_rsp;
    pl(store_start);
    go = 1'b1;
    cyc(31600);
    pl(store_stop);
    go = 1'b0;
    pl(store_read);
    n = 0;
    repeat (110)
    begin
      @(negedge mclk);
      if (rsp_valid === 1'b1)
      begin
        if (n > 0)
          chk(rsp_data, prev + 48'h1);
        if (n == 99)
          chk(rsp_last, 1);
        prev = rsp_data;
        n++;
      end
    end
    chk(48'(n), 48'd100);
    $display("store done");
    report_and_stop;
  end
endmodule // fcr_run_ctrl_test
`default_nettype wire
